// >>> hw/dpsc_sync.sv
/*
  Two-stage synchroniser for the serial and strap pins.
  Assumes the pins are asynchronous to the system clock.
*/
`timescale 1ns/1ps
module dpsc_sync
  import dpsc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // pins
  input  wire dpsc_pkg::dpsc_pins_t pins_i,
  output dpsc_pkg::dpsc_pins_t      pins_o
);
  typedef struct packed {
    dpsc_pins_t meta;
    dpsc_pins_t stable;
  } dpsc_sync_st_t;

  dpsc_sync_st_t st_reg;
  dpsc_sync_st_t st_next;

  // first stage is read only by the second
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = pins_i;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{meta: PINS_IDLE, stable: PINS_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_o = st_reg.stable;

endmodule // dpsc_sync

// >>> hw/dpsc_timer.sv
/*
  Busy timer for nonvolatile save, restore and read. Restarts on each
  start pulse. Assumes start is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
module dpsc_timer
  import dpsc_pkg::*;
#(
  parameter int W = CNT_W
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // control
  input  wire logic         start_i,
  input  wire logic [W-1:0] cycles_i,
  output logic              busy_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } dpsc_tmr_st_t;

  dpsc_tmr_st_t st_reg;
  dpsc_tmr_st_t st_next;

  // count down; busy drops as the count reaches zero
  always_comb begin
    st_next = st_reg;
    if (start_i) begin
      st_next.cnt  = cycles_i;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      st_next.cnt  = st_reg.cnt - W'(1);
      st_next.busy = (st_reg.cnt > W'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_o = st_reg.busy;

endmodule // dpsc_timer

// >>> hw/dpsc_top.sv
/*
  Serial command decoder, wiper scratch registers and nonvolatile wiper
  stores of a dual 256-position potentiometer. Assumes an SPI master on
  the pins, pins asynchronous to CLK_SYS_I, serial clock far below it.
*/
// Overview of operation
// - sixteen-bit frame, MSB first on input
// - instruction, register select, data byte fields
// - decode only when chip select rises
// - instruction 11 writes selected wiper
// - instruction 2 saves wiper, 25 ms
// - power-on loads wipers from stores
// - preset low forces midscale, rise reloads
// - bare chip-select pulse repeats step command
// - write protect blocks serial wiper changes except restore all (8)
// - no-op enters minimum power state
// - serial output released while chip select high
// - idle-low phase 0 or idle-high phase 1
// - reads shift out in next frame
// - other instructions pass bits through chain
// - step commands ignore the data byte
// - instructions 14, 15 increment one/both
// - instructions 6, 7 decrement one/both
// - 4, 5 halve; 12, 13 double
// - doubling above midscale goes to full
// - doubling zero gives one, midscale full
// - halving shifts right, dropping LSB
// - no-op leaves read power state
// - ready low during nonvolatile operations
`timescale 1ns/1ps
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter logic [CNT_W-1:0] SAVE_CYCLES    = CNT_W'(SAVE_CYC),
  parameter logic [CNT_W-1:0] RESTORE_CYCLES = CNT_W'(RESTORE_CYC),
  parameter logic [CNT_W-1:0] READ_CYCLES    = CNT_W'(READ_CYC)
) (
  // clock and reset
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_N_I,
  // serial port
  input  wire logic       SCLK_I,
  input  wire logic       SDI_I,
  input  wire logic       CS_N_I,
  output logic            SDO_O,
  output logic            SDO_OE_N_O,
  // hardware controls
  input  wire logic       PRESET_RELOAD_N_I,
  input  wire logic       WP_N_I,
  output logic            RDY_O,
  output logic            RDY_OE_N_O,
  // wiper state
  output logic [7:0]      WIPER1_O,
  output logic [7:0]      WIPER2_O,
  output logic            LOW_POWER_O
);
  typedef struct packed {
    dpsc_state_t    state;
    logic [15:0]    sr;
    logic [4:0]     bit_cnt;
    logic           sclk_q;
    logic           cs_q;
    logic           pr_q;
    logic           sdo_bit;
    logic [7:0]     wiper1;
    logic [7:0]     wiper2;
    logic [7:0]     store1;
    logic [7:0]     store2;
    logic           rep_valid;
    dpsc_frame_t    rep_frame;
    logic           read_mode;
    logic           save_lock;
    logic           tmr_start;
    dpsc_tmr_kind_t tmr_kind;
    logic           sdo_oe_n;
    logic           rdy_oe_n;
    logic           low_power;
    logic           od_low;
  } dpsc_core_st_t;

  dpsc_core_st_t q;
  dpsc_core_st_t n;
  logic [1:0]    rst_ff;
  logic          rst_n;
  dpsc_pins_t    pins_raw;
  dpsc_pins_t    pins_s;
  logic          tmr_busy;
  logic [CNT_W-1:0] tmr_cycles;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          cs_fall;
  logic          cs_rise;
  logic          pr_rise;
  logic          go;
  logic          wp_ok;
  dpsc_frame_t   f;

  // one step or shift of a wiper code; the data byte never enters
  function automatic logic [7:0] step_op(input dpsc_instr_t ins, input logic [7:0] v);
    case (ins)
      INS_SHR_ONE, INS_SHR_BOTH: step_op = v >> 1;
      INS_DEC_ONE, INS_DEC_BOTH: step_op = (v == CODE_ZERO) ? CODE_ZERO : v - CODE_ONE;
      INS_INC_ONE, INS_INC_BOTH: step_op = (v == CODE_FULL) ? CODE_FULL : v + CODE_ONE;
      INS_SHL_ONE, INS_SHL_BOTH: begin
        if (v == CODE_ZERO) begin
          step_op = CODE_ONE;
        end else if (v >= CODE_MID) begin
          step_op = CODE_FULL;
        end else begin
          step_op = {v[6:0], 1'b0};
        end
      end
      default: step_op = v;
    endcase
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // raw pins gathered into one word for the synchroniser
  assign pins_raw = '{sclk: SCLK_I, sdi: SDI_I, cs_n: CS_N_I, preset_n: PRESET_RELOAD_N_I, wp_n: WP_N_I};

  dpsc_sync u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .pins_i  (pins_raw),
    .pins_o  (pins_s)
  );

  // busy time chosen by the kind of operation last started
  always_comb begin
    case (q.tmr_kind)
      TMR_SAVE: tmr_cycles = SAVE_CYCLES;
      TMR_READ: tmr_cycles = READ_CYCLES;
      default:  tmr_cycles = RESTORE_CYCLES;
    endcase
  end

  dpsc_timer #(.W(CNT_W)) u_timer (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (rst_n),
    .start_i  (q.tmr_start),
    .cycles_i (tmr_cycles),
    .busy_o   (tmr_busy)
  );

  // whole next-state computation
  always_comb begin
    n           = q;
    n.tmr_start = 1'b0;
    n.od_low    = 1'b0;
    sclk_rise   = pins_s.sclk & ~q.sclk_q;
    sclk_fall   = ~pins_s.sclk & q.sclk_q;
    cs_fall     = q.cs_q & ~pins_s.cs_n;
    cs_rise     = ~q.cs_q & pins_s.cs_n;
    pr_rise     = ~q.pr_q & pins_s.preset_n;
    wp_ok       = pins_s.wp_n;
    n.sclk_q    = pins_s.sclk;
    n.cs_q      = pins_s.cs_n;
    n.pr_q      = pins_s.preset_n;
    go          = 1'b0;
    f           = q.sr;

    // both supported modes sample on the rising edge, drive on falling
    if (!pins_s.cs_n && !q.save_lock) begin
      if (cs_fall) begin
        n.bit_cnt = BIT_CNT_ZERO;
      end
      if (sclk_rise) begin
        n.sr = {q.sr[14:0], pins_s.sdi};
        if (q.bit_cnt != BIT_CNT_FULL) begin
          n.bit_cnt = q.bit_cnt + BIT_CNT_ONE;
        end
      end
      if (cs_fall || sclk_fall) begin
        n.sdo_bit = q.sr[15];
      end
    end

    // execute on chip-select release
    if (cs_rise && !q.save_lock && q.state != ST_BOOT) begin
      if (q.bit_cnt == BIT_CNT_FULL) begin
        go = 1'b1;
      end else if (q.bit_cnt == BIT_CNT_ZERO && q.rep_valid) begin
        go = 1'b1;
        f  = q.rep_frame;
      end
    end

    if (go) begin
      n.rep_valid = 1'b0;
      case (f.instr)
        INS_NOP: n.read_mode = 1'b0;
        INS_RESTORE_ONE: begin
          if (wp_ok && f.sel == SEL_WIPER1) n.wiper1 = q.store1;
          if (wp_ok && f.sel == SEL_WIPER2) n.wiper2 = q.store2;
          n.read_mode = 1'b1;
          n.tmr_start = 1'b1;
          n.tmr_kind  = TMR_RESTORE;
        end
        INS_SAVE, INS_SAVE_USER: begin
          if (f.instr == INS_SAVE && f.sel == SEL_WIPER1) n.store1 = q.wiper1;
          if (f.instr == INS_SAVE && f.sel == SEL_WIPER2) n.store2 = q.wiper2;
          n.save_lock = 1'b1;
          n.tmr_start = 1'b1;
          n.tmr_kind  = TMR_SAVE;
        end
        INS_RESTORE_ALL: begin
          n.wiper1    = q.store1;
          n.wiper2    = q.store2;
          n.tmr_start = 1'b1;
          n.tmr_kind  = TMR_RESTORE;
        end
        INS_READ_NV, INS_READ_WIPER: begin
          if (f.sel == SEL_WIPER2) begin
            n.sr[7:0] = (f.instr == INS_READ_NV) ? q.store2 : q.wiper2;
          end else begin
            n.sr[7:0] = (f.instr == INS_READ_NV) ? q.store1 : q.wiper1;
          end
          n.read_mode = 1'b1;
          n.tmr_start = 1'b1;
          n.tmr_kind  = TMR_READ;
        end
        INS_WRITE: begin
          if (wp_ok && f.sel == SEL_WIPER1) n.wiper1 = f.data;
          if (wp_ok && f.sel == SEL_WIPER2) n.wiper2 = f.data;
        end
        default: begin
          // steps and shifts; only the field and select matter
          n.rep_valid = 1'b1;
          n.rep_frame = f;
          if (wp_ok && (f.instr[0] || f.sel == SEL_WIPER1)) n.wiper1 = step_op(f.instr, q.wiper1);
          if (wp_ok && (f.instr[0] || f.sel == SEL_WIPER2)) n.wiper2 = step_op(f.instr, q.wiper2);
        end
      endcase
    end

    // state sequencing: power-on restore, then idle or busy
    case (q.state)
      ST_BOOT: begin
        n.wiper1    = q.store1;
        n.wiper2    = q.store2;
        n.tmr_start = 1'b1;
        n.tmr_kind  = TMR_RESTORE;
        n.state     = ST_BUSY;
      end
      ST_IDLE: begin
        if (n.tmr_start) n.state = ST_BUSY;
      end
      ST_BUSY: begin
        if (!tmr_busy && !q.tmr_start && !n.tmr_start) begin
          n.state     = ST_IDLE;
          n.save_lock = 1'b0;
        end
      end
      default: n.state = ST_IDLE;
    endcase

    // preset pin wins over any frame in the same cycle
    if (!pins_s.preset_n) begin
      n.wiper1 = CODE_MID;
      n.wiper2 = CODE_MID;
    end else if (pr_rise && q.state != ST_BOOT) begin
      n.wiper1    = q.store1;
      n.wiper2    = q.store2;
      n.tmr_start = 1'b1;
      n.tmr_kind  = TMR_RESTORE;
      n.state     = ST_BUSY;
    end

    // pin outputs registered; low enable means pulling low
    n.sdo_oe_n  = pins_s.cs_n | n.sdo_bit;
    n.rdy_oe_n  = ~(tmr_busy | q.tmr_start | ~pins_s.preset_n | (q.state == ST_BOOT));
    n.low_power = ~n.read_mode;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.state     <= ST_BOOT;
      q.sr        <= 16'h0000;
      q.cs_q      <= 1'b1;
      q.pr_q      <= 1'b1;
      q.sdo_bit   <= 1'b1;
      q.wiper1    <= CODE_MID;
      q.wiper2    <= CODE_MID;
      q.store1    <= CODE_MID;   // unprogrammed store holds midscale
      q.store2    <= CODE_MID;
      q.sdo_oe_n  <= 1'b1;
      q.rdy_oe_n  <= 1'b0;
      q.low_power <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign SDO_O       = q.od_low;
  assign SDO_OE_N_O  = q.sdo_oe_n;
  assign RDY_O       = q.od_low;
  assign RDY_OE_N_O  = q.rdy_oe_n;
  assign WIPER1_O    = q.wiper1;
  assign WIPER2_O    = q.wiper2;
  assign LOW_POWER_O = q.low_power;

  // checks
  logic quiet;
  assign quiet = pins_s.preset_n && q.pr_q && q.state != ST_BOOT;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  property p_sdo_off;
    pins_s.cs_n |=> SDO_OE_N_O;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven with cs high");
  property p_pr_mid;
    !pins_s.preset_n |=> (WIPER1_O == CODE_MID) && (WIPER2_O == CODE_MID);
  endproperty
  a_pr_mid: assert property (p_pr_mid) else $error("preset did not force midscale");
  property p_lock;
    q.save_lock && quiet |=> $stable(q.wiper1) && $stable(q.wiper2);
  endproperty
  a_lock: assert property (p_lock) else $error("wiper moved during save");
  property p_wp;
    !pins_s.wp_n && quiet && !(go && f.instr == INS_RESTORE_ALL) |=> $stable(q.wiper1) && $stable(q.wiper2);
  endproperty
  a_wp: assert property (p_wp) else $error("wiper changed under write protect");
  property p_write;
    go && f.instr == INS_WRITE && f.sel == SEL_WIPER1 && pins_s.wp_n && quiet |=> WIPER1_O == $past(f.data);
  endproperty
  a_write: assert property (p_write) else $error("write did not load wiper");
  property p_rdy_save;
    go && f.instr == INS_SAVE |-> ##2 (!RDY_OE_N_O) [*8];
  endproperty
  a_rdy_save: assert property (p_rdy_save) else $error("ready not low during save");
  property p_inc;
    go && f.instr == INS_INC_BOTH && pins_s.wp_n && quiet
      |=> WIPER2_O == (($past(q.wiper2) == CODE_FULL) ? CODE_FULL : $past(q.wiper2) + CODE_ONE);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_shl;
    go && f.instr == INS_SHL_ONE && f.sel == SEL_WIPER1 && pins_s.wp_n && quiet
      |=> WIPER1_O == (($past(q.wiper1) == CODE_ZERO) ? CODE_ONE :
                       ($past(q.wiper1) >= CODE_MID) ? CODE_FULL : {$past(q.wiper1[6:0]), 1'b0});
  endproperty
  a_shl: assert property (p_shl) else $error("6 dB increase wrong");
  property p_dec;
    go && f.instr == INS_DEC_BOTH && pins_s.wp_n && quiet
      |=> WIPER1_O == (($past(q.wiper1) == CODE_ZERO) ? CODE_ZERO : $past(q.wiper1) - CODE_ONE);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_shr;
    go && f.instr == INS_SHR_BOTH && pins_s.wp_n && quiet |=> WIPER2_O == ($past(q.wiper2) >> 1);
  endproperty
  a_shr: assert property (p_shr) else $error("6 dB decrease wrong");
  property p_repeat;
    cs_rise && q.bit_cnt == BIT_CNT_ZERO && q.rep_valid && !q.save_lock && q.state != ST_BOOT
      |-> go && f == q.rep_frame;
  endproperty
  a_repeat: assert property (p_repeat) else $error("step not repeated");
  property p_read;
    go && f.instr == INS_READ_WIPER && f.sel == SEL_WIPER2 |=> q.sr[7:0] == $past(q.wiper2);
  endproperty
  a_read: assert property (p_read) else $error("read data not loaded");
  property p_nop;
    go && f.instr == INS_NOP |=> LOW_POWER_O;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op did not idle");
  c_save: cover property (go && f.instr == INS_SAVE ##1 q.save_lock);
  c_repeat: cover property (go && f == q.rep_frame && q.bit_cnt == BIT_CNT_ZERO);
  c_read: cover property (go && f.instr == INS_READ_NV);

endmodule // dpsc_top

// >>> include/dpsc_pkg.sv
/*
  Shared constants, codes and carrier types for the dual wiper serial
  command controller. Assumes a single 100 MHz system clock.
*/
package dpsc_pkg;

  // clock rate and documented times
  localparam int CLK_MHZ         = 100;
  localparam int SAVE_TIME_US    = 25000;
  localparam int RESTORE_TIME_US = 1000;
  localparam int READ_TIME_US    = 120;
  localparam int SAVE_CYC        = SAVE_TIME_US * CLK_MHZ;
  localparam int RESTORE_CYC     = RESTORE_TIME_US * CLK_MHZ;
  localparam int READ_CYC        = READ_TIME_US * CLK_MHZ;
  localparam int CNT_W           = 22;

  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int DATA_W     = 8;
  localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [4:0] BIT_CNT_ONE  = 5'h01;

  // wiper codes
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] CODE_ONE  = 8'h01;
  localparam logic [7:0] CODE_MID  = 8'h80;
  localparam logic [7:0] CODE_FULL = 8'hFF;

  // register select codes
  localparam logic [3:0] SEL_WIPER1 = 4'h0;
  localparam logic [3:0] SEL_WIPER2 = 4'h1;

  typedef enum logic [3:0] {
    INS_NOP         = 4'h0,
    INS_RESTORE_ONE = 4'h1,
    INS_SAVE        = 4'h2,
    INS_SAVE_USER   = 4'h3,
    INS_SHR_ONE     = 4'h4,
    INS_SHR_BOTH    = 4'h5,
    INS_DEC_ONE     = 4'h6,
    INS_DEC_BOTH    = 4'h7,
    INS_RESTORE_ALL = 4'h8,
    INS_READ_NV     = 4'h9,
    INS_READ_WIPER  = 4'hA,
    INS_WRITE       = 4'hB,
    INS_SHL_ONE     = 4'hC,
    INS_SHL_BOTH    = 4'hD,
    INS_INC_ONE     = 4'hE,
    INS_INC_BOTH    = 4'hF
  } dpsc_instr_t;

  typedef enum logic [1:0] {
    TMR_RESTORE = 2'b00,
    TMR_SAVE    = 2'b01,
    TMR_READ    = 2'b10
  } dpsc_tmr_kind_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } dpsc_state_t;

  // instruction, register select, data byte
  typedef struct packed {
    dpsc_instr_t instr;
    logic [3:0]  sel;
    logic [7:0]  data;
  } dpsc_frame_t;

  // pins from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic cs_n;
    logic preset_n;
    logic wp_n;
  } dpsc_pins_t;

  localparam dpsc_pins_t PINS_IDLE = '{sclk: 1'b0, sdi: 1'b0, cs_n: 1'b1, preset_n: 1'b1, wp_n: 1'b1};

endpackage

// >>> test/dpsc_bench.sv
/*
  self-checking bench for the dual wiper command controller.
  assumes small timer parameters and a pulled-up sdo line.
*/
`timescale 1ns/1ps
module dpsc_bench;
  import dpsc_pkg::*;
  logic        clk, rst_n, pr_n, wp_n;
  logic        sclk, sdi, cs_n;
  logic        sdo, sdo_oe_n, rdy, rdy_oe_n, low_pw;
  logic [7:0]  w1, w2;
  logic [15:0] rx;
  wire logic   sdo_line;
  int          n_errors, compares, cycles;

  // open drain with pull-up
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

  // short timers keep the run brief
  dpsc_top #(.SAVE_CYCLES(22'h000190), .RESTORE_CYCLES(22'h000014), .READ_CYCLES(22'h00000A)) dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .SDI_I(sdi), .CS_N_I(cs_n),
    .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .PRESET_RELOAD_N_I(pr_n), .WP_N_I(wp_n),
    .RDY_O(rdy), .RDY_OE_N_O(rdy_oe_n), .WIPER1_O(w1), .WIPER2_O(w2), .LOW_POWER_O(low_pw)
  );

  dpsc_spi_master m (.clk_i(clk), .sdo_i(sdo_line), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, far above the expected few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic send(input logic [15:0] f);
    logic [31:0] r;
    m.xfer({16'h0000, f}, 16, 1'b0, r);
    rx = r[15:0];
  endtask

  // bounded wait for ready released
  task automatic wait_ready();
    for (int i = 0; i < 600 && rdy_oe_n !== 1'b1; i++) @(negedge clk);
    check(rdy_oe_n, 1'b1, "ready");
  endtask

  task automatic t_boot();
    check(w1, 8'h80, "boot w1");
    check(w2, 8'h80, "boot w2");
    wait_ready();
    check(low_pw, 1'b1, "idle power");
    check(sdo_oe_n, 1'b1, "sdo released");
    check({sdo, rdy}, 16'h0000, "open-drain levels");
    $display("test boot done");
  endtask

  task automatic t_write();
    send(16'hB05A);
    check(w1, 8'h5A, "write w1");
    send(16'hB1F0);
    check(w2, 8'hF0, "write w2");
    $display("test write done");
  endtask

  task automatic t_steps();
    send(16'hB0FF);
    send(16'hE055);
    check(w1, 8'hFF, "inc saturates");
    send(16'h6000);
    check(w1, 8'hFE, "dec one");
    m.strobe();
    check(w1, 8'hFD, "repeat");
    send(16'hF000);
    check({w1, w2}, 16'hFEF1, "inc both");
    send(16'h7000);
    check({w1, w2}, 16'hFDF0, "dec both");
    send(16'hB000);
    send(16'h6000);
    check(w1, 8'h00, "dec saturates");
    $display("test steps done");
  endtask

  task automatic t_shift();
    send(16'hC000);
    check(w1, 8'h01, "double zero");
    send(16'hB081);
    send(16'hC000);
    check(w1, 8'hFF, "double high");
    send(16'hC0AA);
    check(w1, 8'hFF, "full stays");
    send(16'h4000);
    check(w1, 8'h7F, "halve");
    send(16'hD000);
    check({w1, w2}, 16'hFEFF, "double both");
    send(16'h5000);
    check({w1, w2}, 16'h7F7F, "halve both");
    $display("test shift done");
  endtask

  task automatic t_nv();
    send(16'hB033);
    send(16'h2000);
    check(rdy_oe_n, 1'b0, "busy on save");
    send(16'hB099);
    check(w1, 8'h33, "frame during save");
    wait_ready();
    send(16'hB044);
    @(negedge clk);
    pr_n = 1'b0;
    repeat (8) @(negedge clk);
    check(w1, 8'h80, "preset midscale");
    pr_n = 1'b1;
    repeat (8) @(negedge clk);
    wait_ready();
    check(w1, 8'h33, "preset reload");
    $display("test nonvolatile done");
  endtask

  task automatic t_wp();
    @(negedge clk);
    wp_n = 1'b0;
    repeat (4) @(negedge clk);
    send(16'hB011);
    check(w1, 8'h33, "protected write");
    send(16'hE000);
    check(w1, 8'h33, "protected inc");
    send(16'h8000);
    wait_ready();
    check(w2, 8'h80, "restore allowed");
    send(16'h0000);
    wp_n = 1'b1;
    $display("test protect done");
  endtask

  task automatic t_read();
    send(16'hA000);
    check(low_pw, 1'b0, "read power");
    wait_ready();
    send(16'h0000);
    check(rx[7:0], 8'h33, "read wiper");
    check(low_pw, 1'b1, "nop idle");
    send(16'h9000);
    wait_ready();
    send(16'hA100);
    check(rx[7:0], 8'h33, "read store");
    wait_ready();
    send(16'h0000);
    check(rx[7:0], 8'h80, "read wiper2");
    send(16'hB012);
    send(16'h0000);
    check(rx, 16'hB012, "pass through");
    $display("test read done");
  endtask

  // idle-high phase, two-device chain, single restore and user save
  task automatic t_link();
    logic [31:0] r;
    m.xfer({16'h0000, 16'hB1AA}, 16, 1'b1, r);
    check(w2, 8'hAA, "idle-high write");
    m.xfer(32'h00000000, 16, 1'b1, r);
    check(r[15:0], 16'hB1AA, "idle-high return");
    m.xfer({16'hB0C3, 16'hB155}, 32, 1'b0, r);
    check(r[15:0], 16'hB0C3, "chain pass");
    check({w1, w2}, 16'h1255, "chain near frame");
    send(16'h1100);
    check({7'h00, rdy_oe_n, w2}, 16'h0080, "restore one");
    check(low_pw, 1'b0, "restore read power");
    wait_ready();
    send(16'h3000);
    check(rdy_oe_n, 1'b0, "user save busy");
    wait_ready();
    send(16'h0000);
    check(low_pw, 1'b1, "nop idle again");
    $display("test link done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    pr_n  = 1'b1;
    wp_n  = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_boot();
    t_write();
    t_steps();
    t_shift();
    t_nv();
    t_wp();
    t_read();
    t_link();
    complete_run();
  end
endmodule // dpsc_bench

// >>> test/dpsc_spi_master.sv
/*
  spi master model for the bench, idle-low phase 0 or idle-high phase 1.
  assumes the bench clock paces it and sdo has a pull-up.
*/
`timescale 1ns/1ps
module dpsc_spi_master (
  // pacing clock and return line
  input  wire logic clk_i,
  input  wire logic sdo_i,
  // serial pins toward the device
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      cs_n_o
);
  // idle: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
    cs_n_o = 1'b1;
  end

  // half a serial period, 40 ns
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // nbits msb first in either phase; return bits sampled on rising edges
  task automatic xfer(input logic [31:0] tx, input int nbits, input logic cpol, output logic [31:0] rx);
    rx = 32'h00000000;
    @(negedge clk_i);
    sclk_o = cpol;
    // idle level settles first so no false edge lands inside the frame
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o  = tx[i];
      half();
      sclk_o = 1'b1;
      rx = {rx[30:0], sdo_i};
      half();
    end
    sclk_o = cpol;
    half();
    cs_n_o = 1'b1;
    // released data line must not keep the last bit
    sdi_o = ~sdi_o;
    repeat (6) @(negedge clk_i);
  endtask

  // bare chip-select pulse, no clocks
  task automatic strobe();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    half();
    cs_n_o = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
endmodule // dpsc_spi_master
